// ==== core/bit_op_defines.svh ====
// Constants for the single-bit instruction datapath
`ifndef BIT_OP_DEFINES_SVH
`define BIT_OP_DEFINES_SVH

// Flag register bit positions
`define FLAG_ZERO_BIT   2'h0
`define FLAG_CARRY_BIT  2'h1
`define FLAG_AUX_BIT    2'h2
`define FLAG_OVF_BIT    2'h3

// IO register select codes
`define IO_SEL_PORT_A_DATA  3'h0
`define IO_SEL_PORT_A_CTRL  3'h1
`define IO_SEL_PORT_B_DATA  3'h2
`define IO_SEL_PORT_B_CTRL  3'h3
`define IO_SEL_FLAGS    3'h4

// Widths, reset values, the one-bit mask and the accumulator MSB
`define MEM_ADDR_W      6
`define BYTE_RESET      8'h00
`define FLAGS_RESET     4'h0
`define ONE_BIT_MASK    8'h01
`define ACCUM_MSB       3'h7
`define PORT_OE_N_RESET 8'hFF

`endif

// ==== core/bit_op_pkg.sv ====
// Types for the single-bit instruction datapath
`include "bit_op_defines.svh"

package bit_op_pkg;

    // One-hot instruction codes from the sequencer
    typedef enum logic [5:0] {
        OP_NONE      = 6'h00,
        OP_CLEAR_IO  = 6'h01,
        OP_SET_IO    = 6'h02,
        OP_SWAPC_IO  = 6'h04,
        OP_CLEAR_MEM = 6'h08,
        OP_SET_MEM   = 6'h10,
        OP_ROTATE_RC = 6'h20
    } op_type;

    // Whole state of the unit
    typedef struct packed {
        logic [7:0]               accumulator;
        logic [3:0]               flags;
        logic [7:0]               port_a_data;
        logic [7:0]               port_a_ctrl;
        logic [7:0]               port_b_data;
        logic [7:0]               port_b_ctrl;
        logic [7:0]               port_a_s1;
        logic [7:0]               port_a_s2;
        logic [7:0]               port_a_s3;
        logic [7:0]               port_a_lvl;
        logic [7:0]               port_b_s1;
        logic [7:0]               port_b_s2;
        logic [7:0]               port_b_s3;
        logic [7:0]               port_b_lvl;
        logic [7:0]               port_a_oe_n;
        logic [7:0]               port_b_oe_n;
        logic                     mem_we;
        logic [`MEM_ADDR_W-1:0]   mem_addr;
        logic [7:0]               mem_wdata;
    } state_type;

endpackage

// ==== core/bit_operation_unit.sv ====
// Single-bit instruction execution unit with ports, flags and accumulator
`timescale 1ns/100ps
`default_nettype none
`include "bit_op_defines.svh"

module bit_operation_unit (
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    input  wire logic                    op_valid,
    input  wire bit_op_pkg::op_type      op_code,
    input  wire logic [2:0]              bit_index,
    input  wire logic [2:0]              io_sel,
    input  wire logic [`MEM_ADDR_W-1:0]  mem_addr_in,
    input  wire logic [7:0]              mem_rdata,
    input  wire logic                    accum_load,
    input  wire logic [7:0]              accum_load_data,
    input  wire logic [7:0]              port_a_pin_in,
    input  wire logic [7:0]              port_b_pin_in,
    output var  logic [7:0]              accumulator,
    output var  logic [3:0]              flag_reg,
    output var  logic [7:0]              port_a_data_reg,
    output var  logic [7:0]              port_b_data_reg,
    output var  logic [7:0]              port_a_ctrl_reg,
    output var  logic [7:0]              port_b_ctrl_reg,
    output var  logic [7:0]              port_a_oe_n,
    output var  logic [7:0]              port_b_oe_n,
    output var  logic                    mem_we,
    output var  logic [`MEM_ADDR_W-1:0]  mem_addr,
    output var  logic [7:0]              mem_wdata
);

    bit_op_pkg::state_type st_r;
    bit_op_pkg::state_type st_nxt;
    logic [7:0]            bit_mask;
    logic [7:0]            io_rd;
    logic [7:0]            io_wr;
    logic                  io_we;
    logic                  io_bit;
    logic                  old_carry;

    // Index selects one of eight bits
    assign bit_mask = `ONE_BIT_MASK << bit_index;

    // Read side of the selected IO register
    always_comb begin
        if (io_sel == `IO_SEL_PORT_A_DATA) begin
            io_rd = st_r.port_a_data;
        end else if (io_sel == `IO_SEL_PORT_A_CTRL) begin
            io_rd = st_r.port_a_ctrl;
        end else if (io_sel == `IO_SEL_PORT_B_DATA) begin
            io_rd = st_r.port_b_data;
        end else if (io_sel == `IO_SEL_PORT_B_CTRL) begin
            io_rd = st_r.port_b_ctrl;
        end else if (io_sel == `IO_SEL_FLAGS) begin
            io_rd = {4'h0, st_r.flags};
        end else begin
            io_rd = `BYTE_RESET;
        end
    end

    // Bit seen by a swap: pin level when input, latch when output
    always_comb begin
        if (io_sel == `IO_SEL_PORT_A_DATA) begin
            io_bit = st_r.port_a_ctrl[bit_index]
                   ? st_r.port_a_data[bit_index]
                   : st_r.port_a_lvl[bit_index];
        end else if (io_sel == `IO_SEL_PORT_B_DATA) begin
            io_bit = st_r.port_b_ctrl[bit_index]
                   ? st_r.port_b_data[bit_index]
                   : st_r.port_b_lvl[bit_index];
        end else begin
            io_bit = io_rd[bit_index];
        end
    end

    assign old_carry = st_r.flags[`FLAG_CARRY_BIT];

    // Value written back to the IO register
    always_comb begin
        io_we = 1'b0;
        io_wr = io_rd;
        if (op_valid) begin
            case (op_code)
                bit_op_pkg::OP_CLEAR_IO: begin
                    io_we = 1'b1;
                    io_wr = io_rd & ~bit_mask;
                end
                bit_op_pkg::OP_SET_IO: begin
                    io_we = 1'b1;
                    io_wr = io_rd | bit_mask;
                end
                bit_op_pkg::OP_SWAPC_IO: begin
                    io_we = 1'b1;
                    io_wr = old_carry ? (io_rd | bit_mask)
                                      : (io_rd & ~bit_mask);
                end
                default: begin
                    io_we = 1'b0;
                end
            endcase
        end
    end

    // Next state of the whole unit
    always_comb begin
        st_nxt = st_r;
        st_nxt.mem_we = 1'b0;
        // Pins: three stages, level moves once stages two and three agree
        st_nxt.port_a_s1 = port_a_pin_in;
        st_nxt.port_a_s2 = st_r.port_a_s1;
        st_nxt.port_a_s3 = st_r.port_a_s2;
        st_nxt.port_b_s1 = port_b_pin_in;
        st_nxt.port_b_s2 = st_r.port_b_s1;
        st_nxt.port_b_s3 = st_r.port_b_s2;
        // Disagreeing stages keep the old level, no glitch to zero
        st_nxt.port_a_lvl =
            (st_r.port_a_lvl & (st_r.port_a_s2 ^ st_r.port_a_s3))
          | (st_r.port_a_s3 & ~(st_r.port_a_s2 ^ st_r.port_a_s3));
        st_nxt.port_b_lvl =
            (st_r.port_b_lvl & (st_r.port_b_s2 ^ st_r.port_b_s3))
          | (st_r.port_b_s3 & ~(st_r.port_b_s2 ^ st_r.port_b_s3));
        // Sequencer load of the accumulator comes before any rotate
        if (accum_load) begin
            st_nxt.accumulator = accum_load_data;
        end
        // IO write-back decode
        if (io_we) begin
            if (io_sel == `IO_SEL_PORT_A_DATA) begin
                st_nxt.port_a_data = io_wr;
            end else if (io_sel == `IO_SEL_PORT_A_CTRL) begin
                st_nxt.port_a_ctrl = io_wr;
            end else if (io_sel == `IO_SEL_PORT_B_DATA) begin
                st_nxt.port_b_data = io_wr;
            end else if (io_sel == `IO_SEL_PORT_B_CTRL) begin
                st_nxt.port_b_ctrl = io_wr;
            end else if (io_sel == `IO_SEL_FLAGS) begin
                st_nxt.flags = io_wr[3:0];
            end
        end
        if (op_valid) begin
            case (op_code)
                bit_op_pkg::OP_SWAPC_IO: begin
                    // Carry write wins over a swap aimed at the flags
                    st_nxt.flags[`FLAG_CARRY_BIT] = io_bit;
                end
                bit_op_pkg::OP_CLEAR_MEM: begin
                    st_nxt.mem_we    = 1'b1;
                    st_nxt.mem_addr  = mem_addr_in;
                    st_nxt.mem_wdata = mem_rdata & ~bit_mask;
                end
                bit_op_pkg::OP_SET_MEM: begin
                    st_nxt.mem_we    = 1'b1;
                    st_nxt.mem_addr  = mem_addr_in;
                    st_nxt.mem_wdata = mem_rdata | bit_mask;
                end
                bit_op_pkg::OP_ROTATE_RC: begin
                    // Bit 0 must reach carry before the shift drops it
                    st_nxt.flags[`FLAG_CARRY_BIT] =
                        st_nxt.accumulator[0];
                    st_nxt.accumulator = {old_carry,
                        st_nxt.accumulator[`ACCUM_MSB:1]};
                end
                default: begin
                    st_nxt.mem_we = 1'b0;
                end
            endcase
        end
        // Drivers on while the control bit says output, active low enable
        st_nxt.port_a_oe_n = ~st_nxt.port_a_ctrl;
        st_nxt.port_b_oe_n = ~st_nxt.port_b_ctrl;
    end

    // Single state register; all inputs of ports start as inputs
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r <= '0;
            st_r.port_a_oe_n <= `PORT_OE_N_RESET;
            st_r.port_b_oe_n <= `PORT_OE_N_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state flops
    assign accumulator     = st_r.accumulator;
    assign flag_reg        = st_r.flags;
    assign port_a_data_reg = st_r.port_a_data;
    assign port_b_data_reg = st_r.port_b_data;
    assign port_a_ctrl_reg = st_r.port_a_ctrl;
    assign port_b_ctrl_reg = st_r.port_b_ctrl;
    assign port_a_oe_n     = st_r.port_a_oe_n;
    assign port_b_oe_n     = st_r.port_b_oe_n;
    assign mem_we          = st_r.mem_we;
    assign mem_addr        = st_r.mem_addr;
    assign mem_wdata       = st_r.mem_wdata;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_clear_io_bit: assert property (
        op_valid && op_code == bit_op_pkg::OP_CLEAR_IO
            && io_sel == `IO_SEL_PORT_A_DATA
        |=> st_r.port_a_data == $past(st_r.port_a_data & ~bit_mask)
            && st_r.flags == $past(st_r.flags))
        else $error("clear io bit wrong");

    a_set_io_bit: assert property (
        op_valid && op_code == bit_op_pkg::OP_SET_IO
            && io_sel == `IO_SEL_PORT_B_DATA
        |=> st_r.port_b_data == $past(st_r.port_b_data | bit_mask)
            && st_r.flags == $past(st_r.flags))
        else $error("set io bit wrong");

    a_swap_flags_kept: assert property (
        op_valid && op_code == bit_op_pkg::OP_SWAPC_IO
            && io_sel != `IO_SEL_FLAGS
        |=> st_r.flags[0] == $past(st_r.flags[0])
            && st_r.flags[3:2] == $past(st_r.flags[3:2]))
        else $error("swap changed a non-carry flag");

    a_swap_drive_out: assert property (
        op_valid && op_code == bit_op_pkg::OP_SWAPC_IO
            && io_sel == `IO_SEL_PORT_A_DATA && st_r.port_a_ctrl[bit_index]
        |=> st_r.port_a_data[$past(bit_index)] == $past(old_carry)
            && flag_reg[1] == $past(st_r.port_a_data[bit_index]))
        else $error("swap output bit did not take carry");

    a_swap_read_pin: assert property (
        op_valid && op_code == bit_op_pkg::OP_SWAPC_IO
            && io_sel == `IO_SEL_PORT_A_DATA && !st_r.port_a_ctrl[bit_index]
        |=> flag_reg[1] == $past(st_r.port_a_lvl[bit_index]))
        else $error("swap input did not load pin level");

    a_clear_mem_bit: assert property (
        op_valid && op_code == bit_op_pkg::OP_CLEAR_MEM
        |=> mem_we && mem_wdata == $past(mem_rdata & ~bit_mask)
            && mem_addr == $past(mem_addr_in) && $stable(flag_reg))
        else $error("clear memory bit wrong");

    a_set_mem_bit: assert property (
        op_valid && op_code == bit_op_pkg::OP_SET_MEM
        |=> mem_we && mem_wdata == $past(mem_rdata | bit_mask)
            && $stable(flag_reg))
        else $error("set memory bit wrong");

    a_carry_position: assert property (
        op_valid && op_code == bit_op_pkg::OP_SET_IO
            && io_sel == `IO_SEL_FLAGS && bit_index == 3'h1
        |=> flag_reg[1] && flag_reg[0] == $past(flag_reg[0]))
        else $error("carry not at flag bit 1");

    a_direction_drive: assert property (
        port_a_oe_n == ~port_a_ctrl_reg && port_b_oe_n == ~port_b_ctrl_reg)
        else $error("pin enable disagrees with direction");

    a_rotate_carry: assert property (
        op_valid && op_code == bit_op_pkg::OP_ROTATE_RC && !accum_load
        |=> accumulator == {$past(old_carry), $past(st_r.accumulator[7:1])}
            && flag_reg[1] == $past(st_r.accumulator[0]))
        else $error("rotate through carry wrong");

    a_write_single: assert property (
        mem_we && !(op_valid && (op_code == bit_op_pkg::OP_CLEAR_MEM
            || op_code == bit_op_pkg::OP_SET_MEM))
        |=> !mem_we)
        else $error("memory write strobe longer than one cycle");

endmodule // bit_operation_unit

`default_nettype wire

// ==== sim/data_mem_model.sv ====
// Data memory and pin level model facing the bit operation unit
`timescale 1ns/100ps
`default_nettype none

module data_mem_model (
    input  wire logic        clk_sys,
    input  wire logic        mem_we,
    input  wire logic [5:0]  mem_addr,
    input  wire logic [7:0]  mem_wdata,
    input  wire logic [5:0]  mem_addr_in,
    output logic [7:0]       mem_rdata,
    input  wire logic [15:0] io_data,
    input  wire logic [15:0] io_oe_n,
    input  wire logic [15:0] io_ext,
    output logic [15:0]      io_pin
);
    logic [7:0] mem [0:63];

    // Distinct start contents so a wrong address shows
    initial begin
        for (int i = 0; i < 64; i++) begin
            mem[i] = 8'(i * 37) ^ 8'hA3;
        end
    end

    // Write lands only on the strobe edge
    always @(posedge clk_sys) begin
        if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
        end
    end

    // Combinational read, valid in the op cycle
    assign mem_rdata = mem[mem_addr_in];
    // Driven bits show the latch, undriven ones the outside level
    assign io_pin = (~io_oe_n & io_data) | (io_oe_n & io_ext);
endmodule // data_mem_model
`default_nettype wire

// ==== sim/bit_operation_unit_bench.sv ====
// Self-checking bench for the bit operation unit
`timescale 1ns/100ps
`default_nettype none
`include "bit_op_defines.svh"

module bit_operation_unit_bench;
    logic                   clk_sys = 0;
    logic                   rst = 1;
    logic                   op_valid = 0;
    bit_op_pkg::op_type     op_code = bit_op_pkg::OP_NONE;
    logic [2:0]             bit_index = 0;
    logic [2:0]             io_sel = 0;
    logic [`MEM_ADDR_W-1:0] mem_addr_in = 0;
    logic [7:0]             mem_rdata;
    logic                   accum_load = 0;
    logic [7:0]             accum_load_data = 0;
    logic [7:0]             accum_o, pad, pbd, pac, pbc, paoe, pboe, mwd;
    logic [3:0]             flg;
    logic                   mwe;
    logic [`MEM_ADDR_W-1:0] madr;
    logic [15:0]            pin;
    logic [15:0]            ext = 16'h0000;
    int                     failures = 0;
    int                     compares = 0;
    // Shadow by select: A data, A ctrl, B data, B ctrl, flags
    logic [7:0]             r [0:4];
    logic [7:0]             accum_exp;
    logic [7:0]             smem [0:63];

    bit_operation_unit dut_u (.clk_sys(clk_sys), .rst(rst),
        .op_valid(op_valid), .op_code(op_code), .bit_index(bit_index),
        .io_sel(io_sel), .mem_addr_in(mem_addr_in), .mem_rdata(mem_rdata),
        .accum_load(accum_load), .accum_load_data(accum_load_data),
        .port_a_pin_in(pin[7:0]), .port_b_pin_in(pin[15:8]),
        .accumulator(accum_o), .flag_reg(flg),
        .port_a_data_reg(pad), .port_b_data_reg(pbd),
        .port_a_ctrl_reg(pac), .port_b_ctrl_reg(pbc),
        .port_a_oe_n(paoe), .port_b_oe_n(pboe), .mem_we(mwe),
        .mem_addr(madr), .mem_wdata(mwd));

    data_mem_model mem_u (.clk_sys(clk_sys), .mem_we(mwe),
        .mem_addr(madr), .mem_wdata(mwd), .mem_addr_in(mem_addr_in),
        .mem_rdata(mem_rdata), .io_data({pbd, pad}),
        .io_oe_n({pboe, paoe}), .io_ext(ext), .io_pin(pin));

    // 125 MHz system clock
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t byte got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t bit got %b expected %b", $time, got, exp);
        end
    endtask

    // Level the unit should see on a port bit once synchronized
    function automatic logic pin_level(input int s, input int i);
        return r[s + 1][i] ? r[s][i] : ext[(s / 2) * 8 + i];
    endfunction

    task automatic check_state();
        check_byte(accum_o, accum_exp);
        check_byte({4'h0, flg}, r[4]);
        check_byte(pad, r[0]);
        check_byte(pbd, r[2]);
        check_byte(pac, r[1]);
        check_byte(pbc, r[3]);
        check_byte(paoe, ~r[1]);
        check_byte(pboe, ~r[3]);
    endtask

    // One op in one cycle, then idle long enough for pin sync
    task automatic run_op(input logic [5:0] op, input logic [2:0] s,
                          input logic [2:0] i, input logic [5:0] a,
                          input logic w, input logic [7:0] wd);
        logic c;
        logic m;
        c = r[4][1];
        m = op == 6'h08 || op == 6'h10;
        @(posedge clk_sys);
        op_valid <= 1'b1;
        op_code <= bit_op_pkg::op_type'(op);
        bit_index <= i;
        io_sel <= s;
        mem_addr_in <= a;
        accum_load <= w;
        accum_load_data <= wd;
        if (w) accum_exp = wd;
        case (op)
            6'h01: if (s < 5) r[s][i] = 1'b0;
            6'h02: if (s < 5) r[s][i] = 1'b1;
            6'h04: begin
                r[4][1] = pin_level(s, i);
                r[s][i] = c;
            end
            6'h08, 6'h10: smem[a][i] = op[4];
            6'h20: {accum_exp, r[4][1]} = {c, accum_exp};
            default: ;
        endcase
        r[4][7:4] = 4'h0;
        @(posedge clk_sys);
        op_valid <= 1'b0;
        accum_load <= 1'b0;
        #1 check_bit(mwe, m);
        if (m) begin
            check_byte(mwd, smem[a]);
            check_byte({2'h0, madr}, {2'h0, a});
        end
        repeat (4) @(posedge clk_sys);
        #1 check_state();
        check_bit(mwe, 1'b0);
        check_byte(mem_u.mem[a], smem[a]);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Hang guard, well beyond the expected run length
    initial begin
        #300000;
        failures++;
        complete_run();
    end

    initial begin
        logic [2:0] k;
        logic [5:0] op;
        void'($urandom(32'hA577));
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        for (int j = 0; j < 5; j++) r[j] = 8'h00;
        accum_exp = 8'h00;
        smem = mem_u.mem;
        @(posedge clk_sys);
        #1 check_state();
        // Serial out on port A bit 0, then serial in with rotate
        run_op(6'h02, 3'h1, 3'h0, 6'h00, 1'b0, 8'h00);
        run_op(6'h01, 3'h4, 3'h1, 6'h00, 1'b0, 8'h00);
        run_op(6'h04, 3'h0, 3'h0, 6'h00, 1'b0, 8'h00);
        run_op(6'h02, 3'h4, 3'h1, 6'h00, 1'b0, 8'h00);
        run_op(6'h04, 3'h0, 3'h0, 6'h00, 1'b0, 8'h00);
        @(posedge clk_sys);
        ext <= 16'h0001;
        run_op(6'h01, 3'h1, 3'h0, 6'h00, 1'b0, 8'h00);
        run_op(6'h04, 3'h0, 3'h0, 6'h00, 1'b0, 8'h00);
        run_op(6'h20, 3'h0, 3'h0, 6'h00, 1'b1, 8'h5A);
        run_op(6'h08, 3'h0, 3'h7, 6'h3F, 1'b0, 8'h00);
        run_op(6'h10, 3'h0, 3'h0, 6'h3F, 1'b0, 8'h00);
        // Random mix including idle, bad codes and bad selects
        for (int n = 0; n < 1500; n++) begin
            if (n % 16 == 0) begin
                // Pins change on an edge; four edges let the sync settle
                @(posedge clk_sys);
                ext <= 16'($urandom);
                repeat (4) @(posedge clk_sys);
            end
            k = 3'($urandom % 8);
            op = k < 6 ? 6'h01 << k : (k == 6 ? 6'h00 : 6'h03);
            run_op(op, op == 6'h04 ? {1'b0, 2'($urandom % 2) * 2'h2}
                : 3'($urandom), 3'($urandom), 6'($urandom),
                1'($urandom), 8'($urandom));
        end
        complete_run();
    end
endmodule // bit_operation_unit_bench
`default_nettype wire
